// *** logic/daic_pkg.sv ***
package daic_pkg;
  // Register map
  localparam logic [6:0] FMT_CTRL_ADDR = 7'h05;
  localparam logic [6:0] MODE_CTRL_ADDR = 7'h07;
  localparam logic [7:0] FMT_CTRL_RST = 8'h0a;
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic [7:0] FMT_CTRL_MASK = 8'h3f;
  // Field positions
  localparam int WL_LSB = 0;
  localparam int FMT_LSB = 2;
  localparam int LRP_BIT = 4;
  localparam int BCP_BIT = 5;
  localparam int ST_LSB = 0;
  localparam int RATIO_LSB = 2;
  localparam int OSR_LSB = 5;
  localparam int BYP_BIT = 7;
  // Data widths
  localparam int IN_W = 24;
  localparam int WORD_W = 32;
  localparam int DITH_W = 8;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 9;
  localparam int RATIO_W = 10;
  localparam int PER_W = 11;
  localparam logic [6:0] BITS_16 = 7'h10;
  localparam logic [6:0] BITS_20 = 7'h14;
  localparam logic [6:0] BITS_24 = 7'h18;
  localparam logic [6:0] BITS_32 = 7'h20;
  typedef enum logic [1:0] {WL_16 = 2'b00, WL_20 = 2'b01, WL_24 = 2'b10, WL_32 = 2'b11} daic_wl_e;
  typedef enum logic [1:0] {FMT_RJ = 2'b00, FMT_LJ = 2'b01, FMT_I2S = 2'b10, FMT_DSP = 2'b11}
    daic_fmt_e;
  typedef enum logic [1:0] {ST_PCM = 2'b00, ST_DIRECT = 2'b01, ST_FILT = 2'b10, ST_UNUSED = 2'b11}
    daic_stream_e;
  typedef enum logic [1:0] {CTL_HW = 2'b00, CTL_3W = 2'b01, CTL_2W = 2'b10} daic_ctl_e;
  typedef enum logic [1:0] {SP_PULL_LO = 2'b00, SP_PULL_HI = 2'b01, SP_DONE = 2'b10} daic_strap_e;
  // Ratio codes and values in units of fs
  localparam logic [2:0] RATIO_AUTO = 3'h0;
  localparam logic [2:0] BYP_512 = 3'h1;
  localparam logic [2:0] BYP_768 = 3'h2;
  localparam logic [9:0] FS128 = 10'h080;
  localparam logic [9:0] FS192 = 10'h0c0;
  localparam logic [9:0] FS256 = 10'h100;
  localparam logic [9:0] FS384 = 10'h180;
  localparam logic [9:0] FS512 = 10'h200;
  localparam logic [9:0] FS768 = 10'h300;
  // Auto-detect windows, in master clock cycles per frame
  localparam logic [10:0] PER_MIN = 11'h060;
  localparam logic [10:0] PER_T1 = 11'h0a0;
  localparam logic [10:0] PER_T2 = 11'h0e0;
  localparam logic [10:0] PER_T3 = 11'h140;
  localparam logic [10:0] PER_T4 = 11'h1c0;
  localparam logic [10:0] PER_T5 = 11'h280;
  localparam logic [10:0] PER_MAX = 11'h380;
  // Timing
  localparam int SYS_PERIOD_PS = 5000;
  localparam int PULL_SETTLE_NS = 100;
  localparam int PULL_SETTLE_CYC = (PULL_SETTLE_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
endpackage

// *** logic/daic_input_config.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Control-select pin: low hw, high 3-wire, float 2-wire
// - Stream type: PCM, direct or filtered bitstream
// - Word length 16/20/24/32, default 24
// - Framing RJ, LJ, I2S or DSP, default I2S
// - Samples are signed two's complement
// - 24-bit to filters; 32-bit dithered then truncated
// - Frame polarity bit inverts frame clock sense, except in DSP framing where it sets the data delay
// - Swap by inversion lags one sample
// - Sample on rising bit clock by default
// - Bit clock polarity bit inverts sampling edge
// - Bitstream sampled on falling 64fs edge, inverted option
// - Oversampling rate class selection field
// - Ratio field: auto or 128..768fs fixed
// - Bypass bit skips filters for PCM streams, volume only
// - Bypass: manual ratio 512fs or 768fs only
// - Bypass: two data pins, RJ/LJ, MSB first
// - Auto-detect measures master/frame clock ratio
module daic_input_config
  import daic_pkg::*;
(
  input wire logic sys_clk_i, // Master clock, core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic reg_wr_en_i, // Control port write strobe
  input wire logic [6:0] reg_addr_i, // Control port register address
  input wire logic [7:0] reg_wr_data_i, // Control port write data
  output logic [7:0] reg_rd_data_o, // Readback of addressed register
  input wire logic control_select_pin_i, // Control-select pin level
  output logic ctl_sel_pull_up_o, // Weak pull direction on that pin
  output logic [1:0] ctl_mode_o, // Detected control method
  output logic ctl_mode_valid_o, // Control method decided
  input wire logic bit_clk_i, // Bit clock or 64fs bitstream clock
  input wire logic frame_clk_i, // Frame clock
  input wire logic serial_data_i, // PCM data, left data in bypass
  input wire logic serial_data_right_i, // Right data pin in bypass
  input wire logic bitstream_left_in_i, // Left one-bit stream
  input wire logic bitstream_right_in_i, // Right one-bit stream
  output logic [IN_W-1:0] pcm_left_o, // Left sample to filters
  output logic [IN_W-1:0] pcm_right_o, // Right sample to filters
  output logic pcm_valid_o, // One-cycle pulse per sample pair
  output logic [BYTE_W-1:0] bs_left_o, // Eight left stream bits, oldest first
  output logic [BYTE_W-1:0] bs_right_o, // Eight right stream bits
  output logic bs_valid_o, // One-cycle pulse per byte pair
  output logic [1:0] stream_type_o, // Active stream type
  output logic filters_bypassed_o, // Internal filters skipped
  output logic [1:0] osr_o, // Processing rate class
  output logic [RATIO_W-1:0] ratio_fs_o, // Master/frame ratio in fs, 0 if none
  output logic ratio_valid_o // Ratio known
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] fmt_r, fmt_nxt, mode_r, mode_nxt, rd_r, rd_nxt;

  always_comb
  begin
    fmt_nxt = fmt_r;
    mode_nxt = mode_r;
    rd_nxt = 8'h00;
    if (reg_wr_en_i && reg_addr_i == FMT_CTRL_ADDR)
      fmt_nxt = reg_wr_data_i & FMT_CTRL_MASK;
    else if (reg_wr_en_i && reg_addr_i == MODE_CTRL_ADDR)
      mode_nxt = reg_wr_data_i;
    if (reg_addr_i == FMT_CTRL_ADDR)
      rd_nxt = fmt_r;
    else if (reg_addr_i == MODE_CTRL_ADDR)
      rd_nxt = mode_r;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      fmt_r <= FMT_CTRL_RST;
      mode_r <= MODE_CTRL_RST;
      rd_r <= 8'h00;
    end
    else
    begin
      fmt_r <= fmt_nxt;
      mode_r <= mode_nxt;
      rd_r <= rd_nxt;
    end
  end
  assign reg_rd_data_o = rd_r;

  logic [1:0] st_f, osr_f;
  logic [2:0] ratio_code;
  logic byp_f;
  assign st_f = mode_r[ST_LSB +: 2];
  assign osr_f = mode_r[OSR_LSB +: 2];
  assign ratio_code = mode_r[RATIO_LSB +: 3];
  assign byp_f = mode_r[BYP_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Control-select strap: pull low, then high; a floating pin follows the pull
  daic_strap_e sp_r, sp_nxt;
  logic [4:0] sp_tmr_r, sp_tmr_nxt;
  logic sel_s1, sel_s2, smp_lo_r, smp_lo_nxt, cm_vld_r, cm_vld_nxt;
  logic [1:0] cm_r, cm_nxt;

  always_comb
  begin
    sp_nxt = sp_r;
    sp_tmr_nxt = sp_tmr_r + 5'h01;
    smp_lo_nxt = smp_lo_r;
    cm_nxt = cm_r;
    cm_vld_nxt = cm_vld_r;
    case (sp_r)
      SP_PULL_LO:
      begin
        if (sp_tmr_r == 5'(PULL_SETTLE_CYC - 1))
        begin
          smp_lo_nxt = sel_s2;
          sp_nxt = SP_PULL_HI;
          sp_tmr_nxt = 5'h00;
        end
      end
      SP_PULL_HI:
      begin
        if (sp_tmr_r == 5'(PULL_SETTLE_CYC - 1))
        begin
          cm_nxt = smp_lo_r ? CTL_3W : (sel_s2 ? CTL_2W : CTL_HW);
          cm_vld_nxt = 1'b1;
          sp_nxt = SP_DONE;
        end
      end
      default:
        sp_tmr_nxt = sp_tmr_r;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sp_r <= SP_PULL_LO;
      sp_tmr_r <= 5'h00;
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      smp_lo_r <= 1'b0;
      cm_r <= CTL_HW;
      cm_vld_r <= 1'b0;
    end
    else
    begin
      sp_r <= sp_nxt;
      sp_tmr_r <= sp_tmr_nxt;
      sel_s1 <= control_select_pin_i;
      sel_s2 <= sel_s1;
      smp_lo_r <= smp_lo_nxt;
      cm_r <= cm_nxt;
      cm_vld_r <= cm_vld_nxt;
    end
  end
  assign ctl_sel_pull_up_o = (sp_r == SP_PULL_HI);
  assign ctl_mode_o = cm_r;
  assign ctl_mode_valid_o = cm_vld_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Ratio: measure master clocks per frame, or decode the fixed code
  function automatic logic [RATIO_W-1:0] snap(input logic [PER_W-1:0] p);
    if (p < PER_MIN || p > PER_MAX) return 10'h000;
    else if (p < PER_T1) return FS128;
    else if (p < PER_T2) return FS192;
    else if (p < PER_T3) return FS256;
    else if (p < PER_T4) return FS384;
    else if (p < PER_T5) return FS512;
    else return FS768;
  endfunction

  function automatic logic [RATIO_W-1:0] fixed_ratio(input logic [2:0] c);
    case (c)
      3'h1: return FS128;
      3'h2: return FS192;
      3'h3: return FS256;
      3'h4: return FS384;
      3'h5: return FS512;
      3'h6: return FS768;
      default: return 10'h000;
    endcase
  endfunction

  logic fr_s1, fr_s2, fr_s3;
  logic [PER_W-1:0] per_r, per_nxt;
  logic [RATIO_W-1:0] det_r, det_nxt, ratio_r, ratio_nxt;
  logic [1:0] st_o_r, osr_o_r;
  logic bypd_r, bypd_nxt;

  always_comb
  begin
    per_nxt = (per_r == '1) ? per_r : per_r + 11'h001;
    det_nxt = det_r;
    if (fr_s2 && !fr_s3)
    begin
      per_nxt = 11'h001;
      det_nxt = snap(per_r);
    end
    if (byp_f)
      ratio_nxt = (ratio_code == BYP_512) ? FS512 : ((ratio_code == BYP_768) ? FS768 : 10'h000);
    else if (ratio_code == RATIO_AUTO)
      ratio_nxt = det_r;
    else
      ratio_nxt = fixed_ratio(ratio_code);
    bypd_nxt = (st_f == ST_PCM && byp_f) || st_f == ST_DIRECT;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {fr_s1, fr_s2, fr_s3} <= 3'h0;
      per_r <= 11'h000;
      det_r <= 10'h000;
      ratio_r <= 10'h000;
      st_o_r <= ST_PCM;
      osr_o_r <= 2'h0;
      bypd_r <= 1'b0;
    end
    else
    begin
      {fr_s1, fr_s2, fr_s3} <= {frame_clk_i, fr_s1, fr_s2};
      per_r <= per_nxt;
      det_r <= det_nxt;
      ratio_r <= ratio_nxt;
      st_o_r <= st_f;
      osr_o_r <= osr_f;
      bypd_r <= bypd_nxt;
    end
  end
  assign ratio_fs_o = ratio_r;
  assign ratio_valid_o = (ratio_r != 10'h000);
  assign stream_type_o = st_o_r;
  assign osr_o = osr_o_r;
  assign filters_bypassed_o = bypd_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain. Clock sense is switched by a plain XOR, so the polarity and
  // stream fields may only change while the output is muted.
  logic link_clk;
  assign link_clk = bit_clk_i ^ (fmt_r[BCP_BIT] ^ (st_f != ST_PCM));

  logic [1:0] lrst_r;
  logic [7:0] lcfg_s1, lcfg_s2;
  always_ff @(posedge link_clk or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lrst_r <= 2'b00;
      lcfg_s1 <= 8'h00;
      lcfg_s2 <= 8'h00;
    end
    else
    begin
      lrst_r <= {lrst_r[0], 1'b1};
      lcfg_s1 <= {byp_f, st_f, fmt_r[LRP_BIT], fmt_r[FMT_LSB +: 2], fmt_r[WL_LSB +: 2]};
      lcfg_s2 <= lcfg_s1;
    end
  end

  logic l_byp, l_pcm, l_lrp, lr, edg, start, pair_tgl_r, pair_tgl_nxt, lr_d_r, frm_d_r;
  logic [1:0] l_fmt, l_wl;
  logic [6:0] n_bits, shamt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, idx, last_l, last_r;
  logic [WORD_W-1:0] sh_l_r, sh_r_r, sh_l_nxt, sh_r_nxt, wl_new, wl_old, wr_new, wr_old;
  logic [WORD_W-1:0] hold_r, hold_nxt, out_l_r, out_l_nxt, out_r_r, out_r_nxt;
  logic is_left;
  assign {l_byp, l_pcm, l_lrp, l_fmt, l_wl} = {lcfg_s2[7], lcfg_s2[6:5] == ST_PCM, lcfg_s2[4:0]};

  always_comb
  begin
    case (l_wl)
      WL_16: n_bits = BITS_16;
      WL_20: n_bits = BITS_20;
      WL_24: n_bits = BITS_24;
      default: n_bits = BITS_32;
    endcase
    shamt = BITS_32 - n_bits;
    lr = frame_clk_i ^ (l_lrp && l_fmt != FMT_DSP);
    edg = lr ^ lr_d_r;
    if (l_fmt == FMT_DSP && !l_byp)
      start = frame_clk_i && !frm_d_r;
    else if (l_byp)
      start = lr_d_r && !lr;
    else
      start = edg;
    idx = start ? 9'h000 : cnt_r;
    sh_l_nxt = {sh_l_r[WORD_W-2:0], l_pcm ? serial_data_i : bitstream_left_in_i};
    sh_r_nxt = {sh_r_r[WORD_W-2:0], l_pcm ? serial_data_right_i : bitstream_right_in_i};
    wl_new = sh_l_nxt << shamt;
    wl_old = sh_l_r << shamt;
    wr_new = sh_r_nxt << shamt;
    wr_old = sh_r_r << shamt;
    last_l = {2'b00, n_bits} - 9'h001;
    if (!l_byp && (l_fmt == FMT_I2S || (l_fmt == FMT_DSP && !l_lrp)))
      last_l = {2'b00, n_bits};
    last_r = last_l + {2'b00, n_bits};
    is_left = ((l_fmt == FMT_RJ) ? lr_d_r : lr) == (l_fmt != FMT_I2S);
    cnt_nxt = (idx == '1 && l_pcm) ? idx : idx + 9'h001;
    hold_nxt = hold_r;
    out_l_nxt = out_l_r;
    out_r_nxt = out_r_r;
    pair_tgl_nxt = pair_tgl_r;
    if (!l_pcm)
    begin
      if (cnt_r[2:0] == 3'h7)
      begin
        out_l_nxt = {24'h000000, sh_l_nxt[BYTE_W-1:0]};
        out_r_nxt = {24'h000000, sh_r_nxt[BYTE_W-1:0]};
        pair_tgl_nxt = !pair_tgl_r;
      end
    end
    else if (l_byp)
    begin
      if (l_fmt == FMT_RJ ? (!lr_d_r && lr) : (idx == last_l))
      begin
        out_l_nxt = (l_fmt == FMT_RJ) ? wl_old : wl_new;
        out_r_nxt = (l_fmt == FMT_RJ) ? wr_old : wr_new;
        pair_tgl_nxt = !pair_tgl_r;
      end
    end
    else if (l_fmt == FMT_DSP)
    begin
      if (idx == last_l)
        hold_nxt = wl_new;
      if (idx == last_r)
      begin
        out_l_nxt = hold_r;
        out_r_nxt = wl_new;
        pair_tgl_nxt = !pair_tgl_r;
      end
    end
    else if (l_fmt == FMT_RJ ? edg : (idx == last_l))
    begin
      // A pair is published on its right word, so a swapped pair lags one frame
      if (is_left)
        hold_nxt = (l_fmt == FMT_RJ) ? wl_old : wl_new;
      else
      begin
        out_l_nxt = hold_r;
        out_r_nxt = (l_fmt == FMT_RJ) ? wl_old : wl_new;
        pair_tgl_nxt = !pair_tgl_r;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {lr_d_r, frm_d_r, pair_tgl_r} <= 3'h0;
      cnt_r <= 9'h000;
      {sh_l_r, sh_r_r, hold_r, out_l_r, out_r_r} <= '0;
    end
    else
    begin
      {lr_d_r, frm_d_r, pair_tgl_r} <= {lr, frame_clk_i, pair_tgl_nxt};
      cnt_r <= cnt_nxt;
      {sh_l_r, sh_r_r, hold_r} <= {sh_l_nxt, sh_r_nxt, hold_nxt};
      {out_l_r, out_r_r} <= {out_l_nxt, out_r_nxt};
    end
  end

  a_dsp_right: assert property (@(posedge link_clk) disable iff (!lrst_r[1])
    (l_pcm && !l_byp && l_fmt == FMT_DSP && idx == last_r) |=> out_r_r == $past(wl_new))
    else $error("DSP right word not captured at its last bit");

  ////////////////////////////////////////////////////////////////////////////////
  // Back in the core domain; link words stay still for a whole word time
  function automatic logic [IN_W-1:0] to_filter(input logic [WORD_W-1:0] x,
                                                input logic wide, input logic [DITH_W-1:0] d);
    logic signed [WORD_W:0] s;
    s = '0;
    if (!wide) return x[WORD_W-1 -: IN_W];
    s = $signed({x[WORD_W-1], x}) + $signed({25'h0000000, d});
    if (s[WORD_W] != s[WORD_W-1]) s = {2'b00, {(WORD_W-1){1'b1}}};
    return s[WORD_W-1 -: IN_W];
  endfunction

  logic t_s1, t_s2, t_s3, new_smp, pv_r, pv_nxt, bv_r, bv_nxt;
  logic [15:0] lfsr_r, lfsr_nxt;
  logic [IN_W-1:0] pl_r, pl_nxt, pr_r, pr_nxt;
  logic [BYTE_W-1:0] bl_r, bl_nxt, br_r, br_nxt;
  assign new_smp = t_s2 ^ t_s3;

  always_comb
  begin
    {pl_nxt, pr_nxt, bl_nxt, br_nxt} = {pl_r, pr_r, bl_r, br_r};
    lfsr_nxt = lfsr_r;
    pv_nxt = new_smp && st_f == ST_PCM;
    bv_nxt = new_smp && st_f != ST_PCM;
    if (new_smp && st_f == ST_PCM)
    begin
      pl_nxt = to_filter(out_l_r, fmt_r[WL_LSB +: 2] == WL_32, lfsr_r[DITH_W-1:0]);
      pr_nxt = to_filter(out_r_r, fmt_r[WL_LSB +: 2] == WL_32, lfsr_r[15 -: DITH_W]);
      lfsr_nxt = {lfsr_r[14:0], ^(lfsr_r & LFSR_TAPS)};
    end
    else if (new_smp)
    begin
      bl_nxt = out_l_r[BYTE_W-1:0];
      br_nxt = out_r_r[BYTE_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {t_s1, t_s2, t_s3, pv_r, bv_r} <= 5'h00;
      lfsr_r <= LFSR_SEED;
      {pl_r, pr_r, bl_r, br_r} <= '0;
    end
    else
    begin
      {t_s1, t_s2, t_s3, pv_r, bv_r} <= {pair_tgl_r, t_s1, t_s2, pv_nxt, bv_nxt};
      lfsr_r <= lfsr_nxt;
      {pl_r, pr_r, bl_r, br_r} <= {pl_nxt, pr_nxt, bl_nxt, br_nxt};
    end
  end
  assign {pcm_left_o, pcm_right_o, pcm_valid_o} = {pl_r, pr_r, pv_r};
  assign {bs_left_o, bs_right_o, bs_valid_o} = {bl_r, br_r, bv_r};

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_strap_decode: assert property ($rose(ctl_mode_valid_o) |-> ctl_mode_o ==
    ($past(smp_lo_r) ? CTL_3W : ($past(sel_s2) ? CTL_2W : CTL_HW)))
    else $error("Control method does not match strap samples");
  a_fmt_write: assert property ((reg_wr_en_i && reg_addr_i == FMT_CTRL_ADDR) ##1 1'b1
    |-> ##1 reg_addr_i != FMT_CTRL_ADDR || reg_rd_data_o == ($past(reg_wr_data_i, 2) & FMT_CTRL_MASK))
    else $error("Format register readback wrong");
  a_stream_route: assert property (##1 stream_type_o == $past(st_f))
    else $error("Stream type output stale");
  a_bypass_path: assert property ($changed(mode_r) |=> ##1 filters_bypassed_o ==
    ((stream_type_o == ST_PCM && $past(byp_f, 2)) || stream_type_o == ST_DIRECT))
    else $error("Filter bypass output wrong");
  a_osr_field: assert property ($changed(osr_f) |=> osr_o == $past(osr_f))
    else $error("Oversampling class not applied");
  a_ratio_fixed: assert property ((!byp_f && ratio_code != RATIO_AUTO) |=>
    ratio_fs_o == fixed_ratio($past(ratio_code)))
    else $error("Fixed ratio decode wrong");
  a_ratio_bypass: assert property (byp_f && ratio_code == BYP_768 |=> ratio_fs_o == FS768)
    else $error("Bypass ratio not 768fs");
  a_ratio_auto: assert property ((fr_s2 && !fr_s3 && !byp_f && ratio_code == RATIO_AUTO)
    |=> ##1 ratio_fs_o == snap($past(per_r, 2)) || $past(ratio_code) != RATIO_AUTO)
    else $error("Auto ratio not taken from measured period");
  a_trunc_plain: assert property ((new_smp && st_f == ST_PCM && fmt_r[1:0] != WL_32)
    |=> pcm_valid_o && pcm_left_o == $past(out_l_r[WORD_W-1 -: IN_W]))
    else $error("Short word not passed unchanged");
  a_dither_range: assert property ((new_smp && st_f == ST_PCM && fmt_r[1:0] == WL_32)
    |=> $signed(pcm_left_o) - $signed($past(out_l_r[WORD_W-1 -: IN_W])) inside {0, 1})
    else $error("Dithered sample out of range");

  c_pcm32: cover property (pcm_valid_o && fmt_r[1:0] == WL_32);
  c_bypass_pair: cover property (pcm_valid_o && byp_f);
  c_bitstream: cover property (bs_valid_o);
  c_auto_lock: cover property (ratio_code == RATIO_AUTO && ratio_valid_o);
endmodule

// *** tb/daic_source_model.sv ***
`timescale 1ns/1ps
module daic_source_model (
  output logic bit_clk_o, // Bit clock, still between frames
  output logic frame_clk_o, // Frame clock
  output logic data_o // Serial data
);
  initial
  begin
    bit_clk_o = 1'b0;
    frame_clk_o = 1'b1;
    data_o = 1'b0;
  end
  // I2S frame, 32 slots a half. Four idle slots with frame high come first:
  // the block's copy of its settings needs link edges to settle, and the
  // frame edge that opens the left word must be seen after them.
  task automatic send_i2s(input logic [23:0] l, input logic [23:0] r);
    logic [63:0] slots;
    slots = {1'b0, l, 7'h00, 1'b0, r, 7'h00};
    for (int k = 0; k < 68; k++)
    begin
      frame_clk_o = (k < 4) || (k >= 36);
      data_o = (k < 4) ? 1'b0 : slots[67-k];
      #32 bit_clk_o = 1'b1;
      #32 bit_clk_o = 1'b0;
    end
    // Released line must not look like the last bit
    data_o = ~data_o;
  endtask
endmodule

// *** tb/daic_input_config_tb.sv ***
`timescale 1ns/1ps
module daic_input_config_tb;
  import daic_pkg::*;
  logic sys_clk_i, rst_b_i, reg_wr_en_i;
  logic [6:0] reg_addr_i;
  logic [7:0] reg_wr_data_i, reg_rd_data_o;
  logic ctl_sel_pull_up_o, ctl_mode_valid_o, pcm_valid_o, bs_valid_o;
  logic filters_bypassed_o, ratio_valid_o, bclk, fclk, sdata;
  logic [1:0] ctl_mode_o, stream_type_o, osr_o;
  logic [IN_W-1:0] pcm_left_o, pcm_right_o;
  logic [BYTE_W-1:0] bs_left_o, bs_right_o;
  logic [RATIO_W-1:0] ratio_fs_o;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  daic_source_model i_src (.bit_clk_o(bclk), .frame_clk_o(fclk), .data_o(sdata));
  daic_input_config i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .reg_wr_en_i(reg_wr_en_i), .reg_addr_i(reg_addr_i), .reg_wr_data_i(reg_wr_data_i),
    .reg_rd_data_o(reg_rd_data_o), .control_select_pin_i(1'b1),
    .ctl_sel_pull_up_o(ctl_sel_pull_up_o), .ctl_mode_o(ctl_mode_o),
    .ctl_mode_valid_o(ctl_mode_valid_o), .bit_clk_i(bclk), .frame_clk_i(fclk),
    .serial_data_i(sdata), .serial_data_right_i(1'b0), .bitstream_left_in_i(1'b0),
    .bitstream_right_in_i(1'b0), .pcm_left_o(pcm_left_o), .pcm_right_o(pcm_right_o),
    .pcm_valid_o(pcm_valid_o), .bs_left_o(bs_left_o), .bs_right_o(bs_right_o),
    .bs_valid_o(bs_valid_o), .stream_type_o(stream_type_o),
    .filters_bypassed_o(filters_bypassed_o), .osr_o(osr_o), .ratio_fs_o(ratio_fs_o),
    .ratio_valid_o(ratio_valid_o));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Long enough for the strap walk and two frames
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk_i) #1;
    reg_wr_en_i = 1'b1;
    reg_addr_i = a;
    reg_wr_data_i = d;
    @(posedge sys_clk_i) #1;
    reg_wr_en_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic reg_rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i) #1;
    reg_addr_i = a;
    repeat (2) @(posedge sys_clk_i);
    #1;
    check("readback", {16'h0000, exp}, {16'h0000, reg_rd_data_o});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_strap;
    int n;
    n = 0;
    while (ctl_mode_valid_o !== 1'b1 && n < 200)
    begin
      @(posedge sys_clk_i) #1;
      n++;
    end
    check("ctl_mode", 24'h000001, {22'h0, ctl_mode_o});
  endtask
  task automatic t_defaults;
    reg_rd(FMT_CTRL_ADDR, 8'h0a);
    reg_rd(MODE_CTRL_ADDR, 8'h00);
    reg_rd(7'h06, 8'h00);
    reg_wr(FMT_CTRL_ADDR, 8'hff);
    reg_rd(FMT_CTRL_ADDR, 8'h3f);
  endtask
  // Stream type only changed with no audio running; rate class set before audio
  task automatic t_modes;
    for (int s = 0; s < 3; s++)
      for (int o = 0; o < 3; o++)
      begin
        reg_wr(MODE_CTRL_ADDR, {1'b0, o[1:0], 3'h0, s[1:0]});
        check("stream", {22'h0, s[1:0]}, {22'h0, stream_type_o});
        check("osr", {22'h0, o[1:0]}, {22'h0, osr_o});
        check("bypassed", {23'h0, s == 1}, {23'h0, filters_bypassed_o});
      end
    reg_wr(MODE_CTRL_ADDR, 8'h80);
    check("bypassed", 24'h000001, {23'h0, filters_bypassed_o});
  endtask
  task automatic t_ratio;
    logic [9:0] tbl [6];
    tbl = '{FS128, FS192, FS256, FS384, FS512, FS768};
    for (int c = 1; c < 7; c++)
    begin
      reg_wr(MODE_CTRL_ADDR, {3'h0, c[2:0], 2'h0});
      check("ratio", {14'h0, tbl[c-1]}, {14'h0, ratio_fs_o});
      check("ratio_valid", 24'h000001, {23'h0, ratio_valid_o});
    end
    reg_wr(MODE_CTRL_ADDR, {3'h4, BYP_512, 2'h0});
    check("byp_ratio", {14'h0, FS512}, {14'h0, ratio_fs_o});
    reg_wr(MODE_CTRL_ADDR, {3'h4, BYP_768, 2'h0});
    check("byp_ratio", {14'h0, FS768}, {14'h0, ratio_fs_o});
  endtask
  task automatic t_pcm(input logic [7:0] fmt, input logic [23:0] l, input logic [23:0] r,
    input logic [23:0] el, input logic [23:0] er);
    int n;
    n = 0;
    reg_wr(MODE_CTRL_ADDR, 8'h00);
    reg_wr(FMT_CTRL_ADDR, fmt);
    fork
      i_src.send_i2s(l, r);
      while (pcm_valid_o !== 1'b1 && n < 1500)
      begin
        @(posedge sys_clk_i) #1;
        n++;
      end
    join
    check("pcm_valid", 24'h000001, {23'h0, n < 1500});
    check("pcm_left", el, pcm_left_o);
    check("pcm_right", er, pcm_right_o);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b_i = 1'b0;
    reg_wr_en_i = 1'b0;
    reg_addr_i = 7'h00;
    reg_wr_data_i = 8'h00;
    repeat (2) @(posedge sys_clk_i);
    #1 rst_b_i = 1'b1;
    t_strap();
    t_defaults();
    t_modes();
    t_ratio();
    t_pcm(8'h0a, 24'h812345, 24'h7f00a5, 24'h812345, 24'h7f00a5);
    t_pcm(8'h08, 24'h9abcde, 24'h13579b, 24'h9abc00, 24'h135700);
    tally_and_finish();
  end
endmodule
